// *** pkle_card.v ***
// Card-side keep-list exchange: query parser and keep-list reply sender
`timescale 1ns/1ns
`include "pkle_defines.vh"

module pkle_card (
  input  wire        i_sys_clk,      // System clock, 100 MHz
  input  wire        i_rst_b,        // Synchronous reset, active low
  input  wire        i_rx_valid,     // Query byte valid
  input  wire [7:0]  i_rx_byte,      // Query byte
  input  wire        i_rx_last,      // Last byte of query message
  input  wire        i_keep_wr,      // Write one keep-list entry
  input  wire [2:0]  i_keep_idx,     // Entry index written
  input  wire [12:0] i_keep_pid,     // PID for that entry
  input  wire [3:0]  i_keep_count,   // Number of entries in use
  input  wire        i_send_req,     // Unsolicited reply request pulse
  input  wire [7:0]  i_send_ltsid,   // Stream tag for unsolicited reply
  input  wire        i_tx_ready,     // Reply sink ready
  output wire        o_tx_valid,     // Reply byte valid
  output reg  [7:0]  o_tx_byte,      // Reply byte
  output reg         o_tx_last,      // Last byte of reply message
  output reg         o_host_filt,    // Host reported it is filtering
  output reg  [7:0]  o_query_ltsid,  // Stream tag of last good query
  output reg         o_query_ok,     // Good query received, pulse
  output reg         o_query_err     // Malformed query received, pulse
);

  reg  [12:0] keep_mem [0:7];
  reg  [12:0] snap_mem [0:7];
  reg  [3:0]  snap_cnt_r;
  reg  [7:0]  snap_ltsid_r;
  reg  [2:0]  rx_pos_r;
  reg         rx_bad_r;
  reg  [7:0]  rx_ltsid_r;
  reg  [7:0]  rx_filt_r;
  reg         tx_busy_r;
  reg  [4:0]  tx_idx_r;
  reg         pend_r;
  reg  [7:0]  pend_ltsid_r;
  reg         query_go;
  reg         rx_byte_bad;
  reg  [7:0]  msg_ltsid;
  wire [3:0]  live_cnt;
  wire        tx_fire;
  wire        start;
  wire [4:0]  first_last;
  integer     i;

  // Message tags split into bytes by part-select
  localparam [23:0] QUERY_TAG = `PKLE_QUERY_TAG;
  localparam [23:0] REPLY_TAG = `PKLE_REPLY_TAG;

  // Reply byte at a given position
  function [7:0] reply_byte;
    input [4:0]  idx;
    input [3:0]  cnt;
    input [7:0]  ltsid;
    input [12:0] pid;
    begin
      case (idx)
        `PKLE_R_TAG0:  reply_byte = REPLY_TAG[23:16];
        `PKLE_R_TAG1:  reply_byte = REPLY_TAG[15:8];
        `PKLE_R_TAG2:  reply_byte = REPLY_TAG[7:0];
        `PKLE_R_LEN:   reply_byte = {3'h0, cnt, 1'b0} + `PKLE_QUERY_LEN;
        `PKLE_R_LTSID: reply_byte = ltsid;
        `PKLE_R_COUNT: reply_byte = {4'h0, cnt};
        default: begin
          if (idx[0] == 1'b0)
            reply_byte = {`PKLE_ZERO_BITS, pid[12:8]};
          else
            reply_byte = pid[7:0];
        end
      endcase
    end
  endfunction

  // Final byte index of a reply with cnt entries
  function [4:0] last_idx;
    input [3:0] cnt;
    begin
      last_idx = `PKLE_HDR_BYTES + {cnt, 1'b0} - 5'h01;
    end
  endfunction

  // Entry slot addressed by a body byte index
  function [2:0] slot_of;
    input [4:0] idx;
    reg   [4:0] off;
    begin
      off     = idx - `PKLE_HDR_BYTES;
      slot_of = off[3:1];
    end
  endfunction

  assign live_cnt   = (i_keep_count > `PKLE_MAX_ENTRIES) ? `PKLE_MAX_ENTRIES : i_keep_count;
  assign o_tx_valid = tx_busy_r;
  assign tx_fire    = tx_busy_r & i_tx_ready;
  assign start      = pend_r & ~tx_busy_r;
  assign first_last = last_idx(live_cnt);

  always @* begin
    rx_byte_bad = 1'b0;
    case (rx_pos_r)
      `PKLE_Q_TAG0: rx_byte_bad = (i_rx_byte != QUERY_TAG[23:16]);
      `PKLE_Q_TAG1: rx_byte_bad = (i_rx_byte != QUERY_TAG[15:8]);
      `PKLE_Q_TAG2: rx_byte_bad = (i_rx_byte != QUERY_TAG[7:0]);
      `PKLE_Q_LEN:  rx_byte_bad = i_rx_byte[`PKLE_LEN_LONG_BIT] |
                                  (i_rx_byte != `PKLE_QUERY_LEN);
      `PKLE_Q_FILT: rx_byte_bad = (i_rx_byte != `PKLE_FILT_OFF) &
                                  (i_rx_byte != `PKLE_FILT_ON);
      `PKLE_Q_LTSID: rx_byte_bad = 1'b0;
      default:      rx_byte_bad = 1'b1;
    endcase
  end

  // Good query complete this cycle
  always @* begin
    query_go = i_rx_valid & i_rx_last & ~rx_bad_r & ~rx_byte_bad &
               (rx_pos_r == `PKLE_Q_FILT);
  end

  // Query parser
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rx_pos_r      <= `PKLE_Q_TAG0;
      rx_bad_r      <= 1'b0;
      rx_ltsid_r    <= 8'h00;
      rx_filt_r     <= 8'h00;
      o_host_filt   <= 1'b0;
      o_query_ltsid <= 8'h00;
      o_query_ok    <= 1'b0;
      o_query_err   <= 1'b0;
    end else begin
      o_query_ok  <= 1'b0;
      o_query_err <= 1'b0;
      if (i_rx_valid) begin
        if (rx_pos_r == `PKLE_Q_LTSID)
          rx_ltsid_r <= i_rx_byte;
        if (rx_pos_r == `PKLE_Q_FILT)
          rx_filt_r <= i_rx_byte;
        if (i_rx_last) begin
          rx_pos_r <= `PKLE_Q_TAG0;
          rx_bad_r <= 1'b0;
          if (query_go) begin
            o_query_ok    <= 1'b1;
            o_query_ltsid <= rx_ltsid_r;
            o_host_filt   <= (i_rx_byte == `PKLE_FILT_ON);
          end else begin
            o_query_err <= 1'b1;
          end
        end else begin
          rx_bad_r <= rx_bad_r | rx_byte_bad;
          if (rx_pos_r != `PKLE_Q_OVER)
            rx_pos_r <= rx_pos_r + 3'h1;
        end
      end
    end
  end

  // Stream tag of a new request; answered query wins over unsolicited
  always @* begin
    msg_ltsid = i_send_ltsid;
    if (query_go & (i_rx_byte == `PKLE_FILT_ON))
      msg_ltsid = rx_ltsid_r;
  end

  // Keep list written by card logic
  always @(posedge i_sys_clk) begin
    if (i_keep_wr)
      keep_mem[i_keep_idx] <= i_keep_pid;
  end

  // Pending request; a new request wins over the start clear
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pend_r       <= 1'b0;
      pend_ltsid_r <= 8'h00;
    end else begin
      if ((query_go & (i_rx_byte == `PKLE_FILT_ON)) | i_send_req) begin
        pend_r       <= 1'b1;
        pend_ltsid_r <= msg_ltsid;
      // Request handed to the sender
      end else if (start) begin
        pend_r <= 1'b0;
      end
    end
  end

  // Reply sender
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      tx_busy_r    <= 1'b0;
      tx_idx_r     <= `PKLE_R_TAG0;
      snap_cnt_r   <= 4'h0;
      snap_ltsid_r <= 8'h00;
      o_tx_byte    <= 8'h00;
      o_tx_last    <= 1'b0;
    end else if (start) begin
      for (i = 0; i < 8; i = i + 1)
        snap_mem[i] <= keep_mem[i];
      snap_cnt_r   <= live_cnt;
      snap_ltsid_r <= pend_ltsid_r;
      tx_busy_r    <= 1'b1;
      tx_idx_r     <= `PKLE_R_TAG0;
      o_tx_byte    <= reply_byte(`PKLE_R_TAG0, live_cnt, pend_ltsid_r, 13'h0000);
      o_tx_last    <= 1'b0;
    end else if (tx_fire) begin
      if (o_tx_last) begin
        tx_busy_r <= 1'b0;
        o_tx_last <= 1'b0;
      end else begin
        tx_idx_r  <= tx_idx_r + 5'h01;
        o_tx_byte <= reply_byte(tx_idx_r + 5'h01, snap_cnt_r, snap_ltsid_r,
                                snap_mem[slot_of(tx_idx_r + 5'h01)]);
        o_tx_last <= ((tx_idx_r + 5'h01) == last_idx(snap_cnt_r));
      end
    end
  end

endmodule // pkle_card

// *** pkle_card_props.sv ***
// Port assertions for pkle_card
`timescale 1ns/1ns
module pkle_card_props (
  input wire       i_sys_clk, i_rst_b, i_send_req, i_tx_ready, // Inputs
  input wire       o_tx_valid, o_tx_last, o_host_filt, o_query_ok, o_query_err, // Flags
  input wire [7:0] o_tx_byte // Reply byte
);
  reg [4:0] pos_r;
  reg       quiet_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Reply byte index, idle history
  always @(posedge i_sys_clk) begin
    quiet_r <= i_rst_b && !o_tx_valid && !i_send_req;
    if (!i_rst_b || (o_tx_valid && i_tx_ready && o_tx_last)) pos_r <= 5'h00;
    else if (o_tx_valid && i_tx_ready) pos_r <= pos_r + 5'h01;
  end
  AST_EXCL: assert property (!(o_query_ok && o_query_err)) else $error("ok with err");
  AST_PULSE: assert property (o_query_ok |=> !o_query_ok) else $error("long ok");
  AST_ANSWER: assert property (o_query_ok && o_host_filt && !o_tx_valid |=> o_tx_valid)
    else $error("no reply");
  AST_SILENT: assert property (o_query_ok && !o_host_filt && quiet_r && !o_tx_valid
    && !i_send_req |=> !o_tx_valid) else $error("stray reply");
  AST_TAG: assert property ($rose(o_tx_valid) |-> o_tx_byte == 8'h9F) else $error("tag");
  AST_TAG_LO: assert property (o_tx_valid && pos_r == 5'h02 |-> o_tx_byte == 8'h17)
    else $error("tag low");
  AST_HOLD: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("hold");
  AST_COUNT: assert property (o_tx_valid && pos_r == 5'h05 |-> o_tx_byte <= 8'h08)
    else $error("count");
  AST_ZERO: assert property (o_tx_valid && pos_r > 5'h05 && !pos_r[0]
    |-> o_tx_byte[7:5] == 3'h0) else $error("zero bits");
endmodule // pkle_card_props

// *** pkle_defines.vh ***
// Message tags, field layouts and counts for the keep-list exchange
`ifndef PKLE_DEFINES_VH
`define PKLE_DEFINES_VH

`define PKLE_QUERY_TAG      24'h9FA016
`define PKLE_REPLY_TAG      24'h9FA017
`define PKLE_FILT_OFF       8'h00
`define PKLE_FILT_ON        8'h01
`define PKLE_MAX_ENTRIES    4'h8
`define PKLE_LEN_LONG_BIT   7
`define PKLE_QUERY_LEN      8'h02
`define PKLE_HDR_BYTES      5'h06
`define PKLE_PID_W          13
`define PKLE_ZERO_BITS      3'h0

// Query byte positions
`define PKLE_Q_TAG0         3'h0
`define PKLE_Q_TAG1         3'h1
`define PKLE_Q_TAG2         3'h2
`define PKLE_Q_LEN          3'h3
`define PKLE_Q_LTSID        3'h4
`define PKLE_Q_FILT         3'h5
`define PKLE_Q_OVER         3'h6

// Reply byte positions
`define PKLE_R_TAG0         5'h00
`define PKLE_R_TAG1         5'h01
`define PKLE_R_TAG2         5'h02
`define PKLE_R_LEN          5'h03
`define PKLE_R_LTSID        5'h04
`define PKLE_R_COUNT        5'h05

`endif

// *** pkle_host_model.sv ***
// Host partner: sends queries, sinks replies
`timescale 1ns/1ns
module pkle_host_model (
  input  wire       i_sys_clk,  // Clock
  input  wire       i_tx_valid, // Reply valid
  input  wire       i_tx_last,  // Reply end
  input  wire [7:0] i_tx_byte,  // Reply byte
  output reg        o_rx_valid, // Query valid
  output reg        o_rx_last,  // Query end
  output reg  [7:0] o_rx_byte,  // Query byte
  output reg        o_tx_ready  // Sink ready
);
  reg [7:0] got[$];
  reg [7:0] keep_r[$];
  reg       slow = 1'b0;
  reg [7:0] len = 8'h02;
  initial {o_rx_valid, o_rx_last, o_rx_byte, o_tx_ready} = 11'h000;
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_byte);
    if (i_tx_valid && o_tx_ready && i_tx_last) keep_r = got;
    o_tx_ready <= #1 slow ? ~o_tx_ready : 1'b1;
  end
  task send(input [7:0] lt, input [7:0] st);
    reg [47:0] m;
    integer k;
    begin
      m = {24'h9FA016, len, lt, st};
      for (k = 0; k < 6; k++) begin
        @(posedge i_sys_clk) #1;
        {o_rx_valid, o_rx_last, o_rx_byte} = {1'b1, k == 5, m[47 - 8 * k -: 8]};
      end
      @(posedge i_sys_clk) #1;
      {o_rx_valid, o_rx_last, o_rx_byte} = {2'h0, ~o_rx_byte};
    end
  endtask
endmodule // pkle_host_model

// *** tb_pkle_card.sv ***
// Self-checking bench for pkle_card
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s: expected %0h, seen %0h", n, e, g); end end
module tb_pkle_card;
  reg         i_sys_clk = 1'b0;
  reg         i_rst_b = 1'b0;
  reg         i_keep_wr = 1'b0;
  reg  [2:0]  i_keep_idx = 3'h0;
  reg  [12:0] i_keep_pid = 13'h0000;
  reg  [3:0]  i_keep_count = 4'h0;
  reg         i_send_req = 1'b0;
  reg  [7:0]  i_send_ltsid = 8'h00;
  wire        rx_v, rx_l, rdy, o_tx_valid, o_tx_last, o_host_filt, o_query_ok, o_query_err;
  wire [7:0]  rx_b, o_tx_byte, o_query_ltsid;
  reg  [12:0] pid [0:7];
  integer     bad_count = 0, comparisons = 0, cyc = 0, k;
  always #5 i_sys_clk = ~i_sys_clk;
  pkle_card i_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_rx_valid(rx_v),
    .i_rx_byte(rx_b), .i_rx_last(rx_l), .i_keep_wr(i_keep_wr), .i_keep_idx(i_keep_idx),
    .i_keep_pid(i_keep_pid), .i_keep_count(i_keep_count), .i_send_req(i_send_req),
    .i_send_ltsid(i_send_ltsid), .i_tx_ready(rdy), .o_tx_valid(o_tx_valid),
    .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last), .o_host_filt(o_host_filt),
    .o_query_ltsid(o_query_ltsid), .o_query_ok(o_query_ok), .o_query_err(o_query_err));
  pkle_host_model i_host (.i_sys_clk(i_sys_clk), .i_tx_valid(o_tx_valid),
    .i_tx_last(o_tx_last), .i_tx_byte(o_tx_byte), .o_rx_valid(rx_v), .o_rx_last(rx_l),
    .o_rx_byte(rx_b), .o_tx_ready(rdy));
  task reply(input [7:0] lt, input integer n);
    reg [47:0] h;
    reg [7:0]  e;
    integer    w;
    begin
      h = {24'h9FA017, 8'(2 + 2 * n), lt, 8'(n)};
      for (w = 0; w < 300 && i_host.got.size() < 6 + 2 * n; w++) @(posedge i_sys_clk);
      repeat (4) @(posedge i_sys_clk);
      `CHK("size", 6 + 2 * n, i_host.got.size())
      `CHK("kept", 6 + 2 * n, i_host.keep_r.size())
      for (w = 0; w < i_host.got.size() && w < 6 + 2 * n; w++) begin
        e = w < 6 ? h[47 - 8 * w -: 8] : w[0] ? pid[(w - 6) / 2][7:0]
          : {3'h0, pid[(w - 6) / 2][12:8]};
        `CHK("byte", e, i_host.got[w])
      end
    end
  endtask
  task t_on;
    begin
      i_keep_count = 4'h2;
      i_host.slow = 1'b1;
      i_host.got.delete();
      i_host.send(8'h5A, 8'h01);
      `CHK("ok", 1'b1, o_query_ok)
      `CHK("filt", 1'b1, o_host_filt)
      `CHK("ltsid", 8'h5A, o_query_ltsid)
      reply(8'h5A, 2);
    end
  endtask
  task t_off_bad;
    begin
      i_host.slow = 1'b0;
      i_host.got.delete();
      i_host.send(8'h3C, 8'h00);
      @(posedge i_sys_clk) #1;
      `CHK("filt", 1'b0, o_host_filt)
      for (k = 0; k < 3; k++) begin
        i_host.len = (k == 2) ? 8'h82 : 8'h02;
        i_host.send(8'h77, (k == 0) ? 8'h02 : (k == 1) ? 8'hFF : 8'h01);
        `CHK("err", 1'b1, o_query_err)
        `CHK("ltsid", 8'h3C, o_query_ltsid)
      end
      i_host.len = 8'h02;
      repeat (10) @(posedge i_sys_clk);
      `CHK("silent", 0, i_host.got.size())
    end
  endtask
  task t_unsol;
    begin
      @(posedge i_sys_clk) #1;
      i_keep_count = 4'h9;
      i_host.slow = 1'b1;
      i_host.got.delete();
      i_send_ltsid = 8'h33;
      i_send_req = 1'b1;
      @(posedge i_sys_clk) #1;
      i_send_req = 1'b0;
      reply(8'h33, 8);
    end
  endtask
  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    for (k = 0; k < 8; k++) begin
      @(posedge i_sys_clk) #1;
      pid[k] = 13'(k * 13'h0245 + 13'h1C03);
      {i_keep_wr, i_keep_idx, i_keep_pid} = {1'b1, k[2:0], pid[k]};
    end
    @(posedge i_sys_clk) #1 i_keep_wr = 1'b0;
    t_on;
    t_off_bad;
    t_unsol;
    end_sim;
  end
endmodule // tb_pkle_card
bind pkle_card pkle_card_props i_props (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_send_req(i_send_req), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_last(o_tx_last), .o_host_filt(o_host_filt), .o_query_ok(o_query_ok),
  .o_query_err(o_query_err), .o_tx_byte(o_tx_byte));
